// *** desc_field_decode.sv ***
// combinational field decode of one eight-byte descriptor
`timescale 1ns/1ps
module desc_field_decode (
  input wire logic [31:0] desc_lo,
  input wire logic [31:0] desc_hi,
  output descriptor_pkg::desc_fields_t fields
);
  logic [19:0] limit_raw;
  logic [31:0] limit_scaled;
  logic is_code;

  // raw and scaled limit assembly
  assign limit_raw = {desc_hi[descriptor_pkg::HI_LIM_MSB:descriptor_pkg::HI_LIM_LSB],
                      desc_lo[descriptor_pkg::LO_LIM_MSB:0]};
  assign limit_scaled = {limit_raw, {descriptor_pkg::GRAN_SHIFT{1'b1}}};
  assign is_code = desc_hi[descriptor_pkg::HI_CLASS] & desc_hi[descriptor_pkg::HI_EXEC];

  // attribute decode, the spare bit only passes through
  always_comb begin
    fields.base = {desc_hi[descriptor_pkg::HI_BASE_TOP_MSB:descriptor_pkg::HI_BASE_TOP_LSB],
                   desc_hi[descriptor_pkg::HI_BASE_MID_MSB:0],
                   desc_lo[descriptor_pkg::LO_BASE_MSB:descriptor_pkg::LO_BASE_LSB]};
    fields.granular = desc_hi[descriptor_pkg::HI_GRAN];
    fields.limit_bytes = fields.granular ? limit_scaled : {12'h000, limit_raw};
    fields.op32 = is_code & desc_hi[descriptor_pkg::HI_SIZE];
    fields.stack32 = desc_hi[descriptor_pkg::HI_CLASS] & ~desc_hi[descriptor_pkg::HI_EXEC]
                     & desc_hi[descriptor_pkg::HI_SIZE];
    fields.software_spare_bit = desc_hi[descriptor_pkg::HI_SPARE];
    fields.present = desc_hi[descriptor_pkg::HI_PRESENT];
    fields.privilege_level = desc_hi[descriptor_pkg::HI_PL_MSB:descriptor_pkg::HI_PL_LSB];
    fields.code_data = desc_hi[descriptor_pkg::HI_CLASS];
    fields.executable = desc_hi[descriptor_pkg::HI_EXEC];
    fields.accessed = desc_hi[descriptor_pkg::HI_ACCESSED];
    fields.conforming = desc_hi[descriptor_pkg::HI_CLASS] & desc_hi[descriptor_pkg::HI_TYPE_B10];
    fields.expand_down = ~desc_hi[descriptor_pkg::HI_CLASS] & desc_hi[descriptor_pkg::HI_TYPE_B10];
    fields.readable = desc_hi[descriptor_pkg::HI_CLASS] & desc_hi[descriptor_pkg::HI_TYPE_B9];
    fields.writable = ~desc_hi[descriptor_pkg::HI_CLASS] & desc_hi[descriptor_pkg::HI_TYPE_B9];
  end
endmodule

// *** desc_table_mem.sv ***
// model of the descriptor tables in system memory
`timescale 1ns/1ps
module desc_table_mem (
  input wire logic pclk,
  input wire logic fetch,
  input wire logic [2:0] idx,
  output logic desc_valid,
  output logic [31:0] desc_lo,
  output logic [31:0] desc_hi
);
  logic [63:0] tbl [8];
  initial begin
    desc_valid = 1'b0;
    desc_lo = 32'h0;
    desc_hi = 32'h0;
  end
  // whole eight-byte entry one cycle after a fetch, toggling junk when idle
  always @(posedge pclk) begin
    desc_valid <= fetch;
    if (fetch) begin
      {desc_hi, desc_lo} <= tbl[idx];
    end else begin
      {desc_hi, desc_lo} <= ~{desc_hi, desc_lo};
    end
  end
endmodule

// *** descriptor_pkg.sv ***
// constants, field layouts and carrier types shared by the descriptor decoder
package descriptor_pkg;
  // register byte offsets on the apb port
  localparam logic [7:0] OFF_DESC_LO = 8'h00;
  localparam logic [7:0] OFF_DESC_HI = 8'h04;
  localparam logic [7:0] OFF_BASE = 8'h08;
  localparam logic [7:0] OFF_LIMIT = 8'h0c;
  localparam logic [7:0] OFF_ATTR = 8'h10;
  localparam logic [7:0] OFF_ITP_BASE = 8'h14;
  localparam logic [7:0] OFF_ITP_LIMIT = 8'h18;
  localparam logic [7:0] OFF_MODE = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_MASK = 8'h24;
  // upper descriptor word field positions
  localparam int HI_BASE_TOP_MSB = 31;
  localparam int HI_BASE_TOP_LSB = 24;
  localparam int HI_GRAN = 23;
  localparam int HI_SIZE = 22;
  localparam int HI_SPARE = 20;
  localparam int HI_LIM_MSB = 19;
  localparam int HI_LIM_LSB = 16;
  localparam int HI_PRESENT = 15;
  localparam int HI_PL_MSB = 14;
  localparam int HI_PL_LSB = 13;
  localparam int HI_CLASS = 12;
  localparam int HI_EXEC = 11;
  localparam int HI_TYPE_B10 = 10;
  localparam int HI_TYPE_B9 = 9;
  localparam int HI_ACCESSED = 8;
  localparam int HI_BASE_MID_MSB = 7;
  // lower descriptor word field positions
  localparam int LO_BASE_MSB = 31;
  localparam int LO_BASE_LSB = 16;
  localparam int LO_LIM_MSB = 15;
  // limit unit of 4 KB is a shift of twelve
  localparam int GRAN_SHIFT = 12;
  // interrupt vector array geometry
  localparam int VECTOR_COUNT = 256;
  localparam logic [10:0] ENTRY_BYTES_PROT = 11'h008;
  localparam logic [10:0] ENTRY_BYTES_REAL = 11'h004;
  // reset values
  localparam logic [31:0] ITP_BASE_RST = 32'h0000_0000;
  localparam logic [15:0] ITP_LIMIT_RST = 16'h03ff;
  localparam logic MODE_PROT_RST = 1'b0;
  // event bits of the status and mask registers
  localparam int EV_NOT_PRESENT = 0;
  localparam int EV_VECTOR_FAULT = 1;
  localparam int EV_TABLE_LOAD = 2;
  localparam int EV_WIDTH = 3;

  // decoded view of one descriptor
  typedef struct packed {
    logic [31:0] base;
    logic [31:0] limit_bytes;
    logic software_spare_bit;
    logic readable;
    logic writable;
    logic conforming;
    logic expand_down;
    logic accessed;
    logic executable;
    logic code_data;
    logic [1:0] privilege_level;
    logic present;
    logic stack32;
    logic op32;
    logic granular;
  } desc_fields_t;

  // interrupt table pointer image: limit then linear base
  typedef struct packed {
    logic [15:0] limit;
    logic [31:0] base;
  } table_ptr_t;
endpackage

// *** event_status.sv ***
// sticky event status with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ps
module event_status #(
  parameter int WIDTH = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] event_set,
  input wire logic status_we,
  input wire logic mask_we,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] status_q,
  output logic [WIDTH-1:0] mask_q,
  output logic irq
);
  // per bit: a set in the same cycle beats the clear
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        status_q[i] <= 1'b0;
      end else if (event_set[i]) begin
        status_q[i] <= 1'b1;
      end else if (status_we && wdata[i]) begin
        status_q[i] <= 1'b0;
      end
    end
  end

  // mask register, one enables the bit onto irq
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
    end else if (mask_we) begin
      mask_q <= wdata;
    end
  end

  assign irq = |(status_q & mask_q);
endmodule

// *** segment_descriptor_decoder.sv ***
// descriptor decoder with interrupt table pointer and apb register port
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module segment_descriptor_decoder #(
  parameter int VECTORS = descriptor_pkg::VECTOR_COUNT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic desc_valid,
  input wire logic [31:0] desc_lo,
  input wire logic [31:0] desc_hi,
  input wire logic seg_reg_load,
  output descriptor_pkg::desc_fields_t decoded,
  output logic decoded_valid,
  output logic not_present_fault,
  input wire logic load_int_table_op,
  input wire descriptor_pkg::table_ptr_t table_operand,
  input wire logic store_int_table_op,
  output descriptor_pkg::table_ptr_t store_data,
  output logic store_valid,
  input wire logic vector_valid,
  input wire logic [7:0] vector_num,
  output logic [31:0] entry_addr,
  output logic entry_valid,
  output logic vector_fault,
  output logic irq
);
  // captured raw descriptor words
  logic [31:0] desc_lo_q;
  logic [31:0] desc_hi_q;
  // decoded fields straight from the words
  descriptor_pkg::desc_fields_t fields;
  // words fed to the decode, the fresh pair while a fetch lands
  logic [31:0] dec_lo;
  logic [31:0] dec_hi;
  // interrupt table pointer
  descriptor_pkg::table_ptr_t itp_q;
  // protected mode select, steers entry size
  logic mode_prot_q;
  // apb decode terms
  logic setup;
  logic access;
  logic wr_en;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [31:0] attr_word;
  // vector lookup terms
  logic [10:0] entry_bytes;
  logic [10:0] entry_off;
  logic [10:0] entry_end;
  logic entry_over;
  // event plumbing
  logic [descriptor_pkg::EV_WIDTH-1:0] ev_set;
  logic [descriptor_pkg::EV_WIDTH-1:0] ev_status;
  logic [descriptor_pkg::EV_WIDTH-1:0] ev_mask;
  logic status_we;
  logic mask_we;

  // a landing fetch is decoded at once, so decoded lines up with decoded_valid
  assign dec_lo = desc_valid ? desc_lo : desc_lo_q;
  assign dec_hi = desc_valid ? desc_hi : desc_hi_q;

  // all descriptor kinds pass through one base/limit/type decode
  desc_field_decode u_decode (
    .desc_lo(dec_lo),
    .desc_hi(dec_hi),
    .fields(fields)
  );

  // apb phase terms, no wait states in access
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = access;
  assign wr_en = access & pwrite & addr_ok;

  // descriptor words captured from the table read or from software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desc_lo_q <= 32'h0000_0000;
      desc_hi_q <= 32'h0000_0000;
    end else if (desc_valid) begin
      desc_lo_q <= desc_lo;
      desc_hi_q <= desc_hi;
    end else if (wr_en && paddr == descriptor_pkg::OFF_DESC_LO) begin
      desc_lo_q <= pwdata;
    end else if (wr_en && paddr == descriptor_pkg::OFF_DESC_HI) begin
      desc_hi_q <= pwdata;
    end
  end

  // decoded result follows one cycle after the words land
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decoded <= '0;
      decoded_valid <= 1'b0;
    end else begin
      decoded <= fields;
      decoded_valid <= desc_valid;
    end
  end

  // load pulse with an absent descriptor raises the fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      not_present_fault <= 1'b0;
    end else begin
      not_present_fault <= desc_valid & seg_reg_load
                           & ~desc_hi[descriptor_pkg::HI_PRESENT];
    end
  end

  // table pointer: load op wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      itp_q.base <= descriptor_pkg::ITP_BASE_RST;
      itp_q.limit <= descriptor_pkg::ITP_LIMIT_RST;
    end else if (load_int_table_op) begin
      itp_q <= table_operand;
    end else if (wr_en && paddr == descriptor_pkg::OFF_ITP_BASE) begin
      itp_q.base <= pwdata;
    end else if (wr_en && paddr == descriptor_pkg::OFF_ITP_LIMIT) begin
      itp_q.limit <= pwdata[15:0];
    end
  end

  // store op copies the whole pointer out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_data <= '0;
      store_valid <= 1'b0;
    end else begin
      store_valid <= store_int_table_op;
      if (store_int_table_op) begin
        store_data <= itp_q;
      end
    end
  end

  // mode select, held in software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_prot_q <= descriptor_pkg::MODE_PROT_RST;
    end else if (wr_en && paddr == descriptor_pkg::OFF_MODE) begin
      mode_prot_q <= pwdata[0];
    end
  end

  // entry size by mode, offset is vector times size
  assign entry_bytes = mode_prot_q ? descriptor_pkg::ENTRY_BYTES_PROT
                                   : descriptor_pkg::ENTRY_BYTES_REAL;
  assign entry_off = mode_prot_q ? {vector_num, 3'b000} : {1'b0, vector_num, 2'b00};
  assign entry_end = 11'(entry_off + entry_bytes - 11'h001);
  // whole entry must sit inside the limit, vectors beyond the array fault too
  assign entry_over = ({5'h00, entry_end} > itp_q.limit)
                      || (32'(vector_num) >= 32'(VECTORS));

  // entry address from the linear base, fault flagged instead of valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_addr <= 32'h0000_0000;
      entry_valid <= 1'b0;
      vector_fault <= 1'b0;
    end else begin
      entry_valid <= vector_valid & ~entry_over;
      vector_fault <= vector_valid & entry_over;
      if (vector_valid) begin
        entry_addr <= itp_q.base + {21'h000000, entry_off};
      end
    end
  end

  // decoded attributes packed for the attribute register read
  assign attr_word = {16'h0000,
                      fields.software_spare_bit,
                      fields.readable,
                      fields.writable,
                      fields.conforming,
                      fields.expand_down,
                      fields.accessed,
                      fields.executable,
                      fields.code_data,
                      fields.privilege_level,
                      fields.present,
                      fields.stack32,
                      fields.op32,
                      fields.granular,
                      ~|fields.privilege_level,
                      &fields.privilege_level};

  // address decode and read data selection
  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      descriptor_pkg::OFF_DESC_LO: begin
        rd_mux = desc_lo_q;
      end
      descriptor_pkg::OFF_DESC_HI: begin
        rd_mux = desc_hi_q;
      end
      descriptor_pkg::OFF_BASE: begin
        rd_mux = fields.base;
      end
      descriptor_pkg::OFF_LIMIT: begin
        rd_mux = fields.limit_bytes;
      end
      descriptor_pkg::OFF_ATTR: begin
        rd_mux = attr_word;
      end
      descriptor_pkg::OFF_ITP_BASE: begin
        rd_mux = itp_q.base;
      end
      descriptor_pkg::OFF_ITP_LIMIT: begin
        rd_mux = {16'h0000, itp_q.limit};
      end
      descriptor_pkg::OFF_MODE: begin
        rd_mux = {31'h00000000, mode_prot_q};
      end
      descriptor_pkg::OFF_STATUS: begin
        rd_mux = {29'h00000000, ev_status};
      end
      descriptor_pkg::OFF_MASK: begin
        rd_mux = {29'h00000000, ev_mask};
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // read data captured in the setup cycle, shown in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // unmapped addresses answer with an error
  assign pslverr = access & ~addr_ok;

  // events into the sticky status
  assign ev_set[descriptor_pkg::EV_NOT_PRESENT] = desc_valid & seg_reg_load
                                                  & ~desc_hi[descriptor_pkg::HI_PRESENT];
  assign ev_set[descriptor_pkg::EV_VECTOR_FAULT] = vector_valid & entry_over;
  assign ev_set[descriptor_pkg::EV_TABLE_LOAD] = load_int_table_op;
  assign status_we = wr_en && paddr == descriptor_pkg::OFF_STATUS;
  assign mask_we = wr_en && paddr == descriptor_pkg::OFF_MASK;

  event_status #(
    .WIDTH(descriptor_pkg::EV_WIDTH)
  ) u_events (
    .pclk(pclk),
    .presetn(presetn),
    .event_set(ev_set),
    .status_we(status_we),
    .mask_we(mask_we),
    .wdata(pwdata[descriptor_pkg::EV_WIDTH-1:0]),
    .status_q(ev_status),
    .mask_q(ev_mask),
    .irq(irq)
  );
endmodule

// *** segment_descriptor_decoder_properties.sv ***
// assertions on the decoder's port behaviour
`timescale 1ns/1ps
module segment_descriptor_decoder_checker #(
  parameter int VECTORS = 256
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic desc_valid,
  input wire logic [31:0] desc_lo,
  input wire logic [31:0] desc_hi,
  input wire logic seg_reg_load,
  input wire descriptor_pkg::desc_fields_t decoded,
  input wire logic decoded_valid,
  input wire logic not_present_fault,
  input wire logic store_int_table_op,
  input wire logic store_valid,
  input wire logic vector_valid,
  input wire logic entry_valid,
  input wire logic vector_fault
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_dec; desc_valid |=> decoded_valid; endproperty
  a_dec: assert property (p_dec) else $error("no decode pulse");
  property p_np; not_present_fault == $past(desc_valid & seg_reg_load & ~desc_hi[15]); endproperty
  a_np: assert property (p_np) else $error("not present fault wrong");
  property p_base; desc_valid |=> decoded.base == {$past(desc_hi[31:24]), $past(desc_hi[7:0]), $past(desc_lo[31:16])};
  endproperty
  a_base: assert property (p_base) else $error("base wrong");
  property p_lim; desc_valid && !desc_hi[23] |=> decoded.limit_bytes == {12'h000, $past(desc_hi[19:16]), $past(desc_lo[15:0])};
  endproperty
  a_lim: assert property (p_lim) else $error("byte limit wrong");
  property p_gran; desc_valid && desc_hi[23] |=> decoded.limit_bytes == {$past(desc_hi[19:16]), $past(desc_lo[15:0]), 12'hfff};
  endproperty
  a_gran: assert property (p_gran) else $error("granular limit wrong");
  property p_size; desc_valid |=> decoded.op32 == $past(desc_hi[22] & desc_hi[12] & desc_hi[11])
    && decoded.stack32 == $past(desc_hi[22] & desc_hi[12] & ~desc_hi[11]); endproperty
  a_size: assert property (p_size) else $error("size select wrong");
  property p_cls; desc_valid |=> decoded.privilege_level == $past(desc_hi[14:13]) && decoded.code_data == $past(desc_hi[12])
    && decoded.executable == $past(desc_hi[11]) && decoded.accessed == $past(desc_hi[8]); endproperty
  a_cls: assert property (p_cls) else $error("class fields wrong");
  property p_typ; desc_valid |=> decoded.conforming == $past(desc_hi[12] & desc_hi[10])
    && decoded.expand_down == $past(~desc_hi[12] & desc_hi[10]) && decoded.readable == $past(desc_hi[12] & desc_hi[9])
    && decoded.writable == $past(~desc_hi[12] & desc_hi[9]); endproperty
  a_typ: assert property (p_typ) else $error("type bits wrong");
  property p_vec; vector_valid |=> entry_valid != vector_fault; endproperty
  a_vec: assert property (p_vec) else $error("vector answer wrong");
  property p_st; store_valid == $past(store_int_table_op); endproperty
  a_st: assert property (p_st) else $error("store pulse wrong");
endmodule
bind segment_descriptor_decoder segment_descriptor_decoder_checker #(.VECTORS(VECTORS)) chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .desc_valid(desc_valid), .desc_lo(desc_lo),
  .desc_hi(desc_hi), .seg_reg_load(seg_reg_load), .decoded(decoded), .decoded_valid(decoded_valid),
  .not_present_fault(not_present_fault), .store_int_table_op(store_int_table_op), .store_valid(store_valid),
  .vector_valid(vector_valid), .entry_valid(entry_valid), .vector_fault(vector_fault));

// *** test_segment_descriptor_decoder.sv ***
// self-checking bench of the segment descriptor decoder
`timescale 1ns/1ps
module test_segment_descriptor_decoder;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, seg_reg_load = 1'b0, fetch = 1'b0;
  logic load_int_table_op = 1'b0, store_int_table_op = 1'b0, vector_valid = 1'b0, prot = 1'b0;
  logic [7:0] paddr = 8'h00, vector_num = 8'h00;
  logic [31:0] pwdata = 32'h0, base_now = 32'h0;
  logic [2:0] fetch_idx = 3'h0;
  logic [15:0] lim_now = 16'h0;
  logic pready, pslverr, desc_valid, decoded_valid, not_present_fault, store_valid, entry_valid, vector_fault, irq;
  logic [31:0] prdata, desc_lo, desc_hi, entry_addr;
  descriptor_pkg::table_ptr_t table_operand = '0;
  descriptor_pkg::table_ptr_t store_data;
  descriptor_pkg::desc_fields_t decoded;
  logic [79:0] exq[$];
  string exn[$];
  int error_cnt = 0;
  int comparisons = 0;
  always #4 pclk = ~pclk;
  segment_descriptor_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .desc_valid(desc_valid),
    .desc_lo(desc_lo), .desc_hi(desc_hi), .seg_reg_load(seg_reg_load), .decoded(decoded),
    .decoded_valid(decoded_valid), .not_present_fault(not_present_fault), .load_int_table_op(load_int_table_op),
    .table_operand(table_operand), .store_int_table_op(store_int_table_op), .store_data(store_data),
    .store_valid(store_valid), .vector_valid(vector_valid), .vector_num(vector_num), .entry_addr(entry_addr),
    .entry_valid(entry_valid), .vector_fault(vector_fault), .irq(irq));
  desc_table_mem mem (.pclk(pclk), .fetch(fetch), .idx(fetch_idx), .desc_valid(desc_valid), .desc_lo(desc_lo),
    .desc_hi(desc_hi));
  task end_of_test();
    if (exq.size() != 0) begin
      error_cnt++;
      $display("mismatch pending expected 0 seen %0d", exq.size());
    end
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string name, input logic [79:0] exp, input logic [79:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task note(input string name, input logic [79:0] v);
    exn.push_back(name);
    exq.push_back(v);
  endtask
  task take(input logic [79:0] got);
    if (exq.size() == 0) begin
      error_cnt++;
      $display("mismatch unexpected expected none seen %h", got);
    end else chk(exn.pop_front(), exq.pop_front(), got);
  endtask
  // result watcher: oldest note against each result that appears
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      if ((psel & penable & pready & ~pwrite) === 1'b1) take({47'h0, pslverr, prdata});
      if (decoded_valid === 1'b1) take({15'h0, not_present_fault, decoded.base, decoded.limit_bytes});
      if ((entry_valid | vector_fault) === 1'b1) take({46'h0, vector_fault, entry_valid, vector_fault ? 32'h0 : entry_addr});
      if (store_valid === 1'b1) take({32'h0, store_data});
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("mismatch pready expected 1 seen %b", pready);
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] v);
    note("register read", {47'h0, v});
    apb(1'b0, a, 32'h0);
  endtask
  task fetch_desc(input logic [2:0] i, input logic sl);
    fetch <= 1'b1;
    fetch_idx <= i;
    @(posedge pclk);
    fetch <= 1'b0;
    seg_reg_load <= sl;
    @(posedge pclk);
    seg_reg_load <= 1'b0;
  endtask
  task load_tbl(input logic [31:0] b, input logic [15:0] l);
    table_operand <= {l, b};
    load_int_table_op <= 1'b1;
    @(posedge pclk);
    load_int_table_op <= 1'b0;
    base_now = b;
    lim_now = l;
  endtask
  // expected entry address or fault from mode, base and limit
  task vec(input logic [7:0] v);
    logic [31:0] sz, off;
    sz = prot ? 32'h8 : 32'h4;
    off = {24'h0, v} * sz;
    if (off + sz - 32'h1 > {16'h0, lim_now}) note("vector fault", {46'h0, 2'b10, 32'h0});
    else note("entry address", {46'h0, 2'b01, base_now + off});
    vector_valid <= 1'b1;
    vector_num <= v;
    @(posedge pclk);
    vector_valid <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [79:0] dexp(input logic [31:0] lo, input logic [31:0] hi, input logic sl);
    logic [19:0] lim;
    lim = {hi[19:16], lo[15:0]};
    return {15'h0, sl & ~hi[15], hi[31:24], hi[7:0], lo[31:16], hi[23] ? {lim, 12'hfff} : {12'h0, lim}};
  endfunction
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    $display("mismatch watchdog expected finish seen hang");
    end_of_test();
  end
  // main sequence
  initial begin
    logic [31:0] lo, hi, b;
    void'($urandom(84));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(descriptor_pkg::OFF_ITP_BASE, {1'b0, descriptor_pkg::ITP_BASE_RST});
    rd(descriptor_pkg::OFF_ITP_LIMIT, {17'h0, descriptor_pkg::ITP_LIMIT_RST});
    rd(descriptor_pkg::OFF_MASK, 33'h0);
    rd(8'h28, 33'h1_0000_0000);
    for (int i = 0; i < 8; i++) begin
      lo = $urandom();
      hi = $urandom();
      hi[23] = i[0];
      hi[12] = i[2];
      hi[15] = (i != 2) && (i != 5);
      mem.tbl[i] = {hi, lo};
      note("descriptor", dexp(lo, hi, i[1]));
      fetch_desc(i[2:0], i[1]);
    end
    apb(1'b1, descriptor_pkg::OFF_DESC_LO, 32'h1234_5678);
    apb(1'b1, descriptor_pkg::OFF_DESC_HI, 32'h00d0_fa00);
    rd(descriptor_pkg::OFF_DESC_LO, {1'b0, 32'h1234_5678});
    rd(descriptor_pkg::OFF_BASE, {1'b0, 32'h0000_1234});
    rd(descriptor_pkg::OFF_LIMIT, {1'b0, 32'h0567_8fff});
    rd(descriptor_pkg::OFF_ATTR, {1'b0, 32'h0000_c3ed});
    apb(1'b1, descriptor_pkg::OFF_ITP_LIMIT, 32'hffff_0123);
    apb(1'b1, descriptor_pkg::OFF_ITP_BASE, 32'h0001_0000);
    rd(descriptor_pkg::OFF_ITP_LIMIT, {17'h0, 16'h0123});
    rd(descriptor_pkg::OFF_ITP_BASE, {1'b0, 32'h0001_0000});
    rd(descriptor_pkg::OFF_STATUS, 33'h1);
    b = $urandom();
    load_tbl(b, 16'h07ff);
    note("stored pointer", {32'h0, 16'h07ff, b});
    store_int_table_op <= 1'b1;
    @(posedge pclk);
    store_int_table_op <= 1'b0;
    rd(descriptor_pkg::OFF_ITP_BASE, {1'b0, b});
    for (int m = 1; m >= 0; m--) begin
      for (int k = 0; k < 2; k++) begin
        prot = m[0];
        apb(1'b1, descriptor_pkg::OFF_MODE, {31'h0, m[0]});
        load_tbl(b, (m[0] ? 16'h07ff : 16'h03ff) - k[15:0]);
        vec(8'h00);
        vec(8'hfe);
        vec(8'hff);
        vec(8'($urandom()));
      end
    end
    chk("irq masked", 80'h0, {79'h0, irq});
    apb(1'b1, descriptor_pkg::OFF_MASK, 32'h2);
    chk("irq raised", 80'h1, {79'h0, irq});
    apb(1'b1, descriptor_pkg::OFF_STATUS, 32'h2);
    chk("irq cleared", 80'h0, {79'h0, irq});
    rd(descriptor_pkg::OFF_STATUS, 33'h5);
    end_of_test();
  end
endmodule
